// [hw/pc_stack_pkg.sv]
// Purpose: shared constants for program counter, return stack and indirect addressing
// Assumes: one instruction executes per cycle when its strobe is high
// Notes:   widths follow the core's program and data space
package pc_stack_pkg;
    localparam int PC_WIDTH      = 13;
    localparam int LOW_WIDTH     = 8;
    localparam int UPPER_WIDTH   = 5;
    localparam int PAGE_WIDTH    = 11;
    localparam int PAGE_SEL_HI   = 4;
    localparam int PAGE_SEL_LO   = 3;
    localparam int STACK_DEPTH   = 8;
    localparam int STACK_PTR_W   = 3;
    localparam int DATA_WIDTH    = 8;
    localparam int DADDR_WIDTH   = 9;
    localparam logic [PC_WIDTH-1:0]    PC_RESET     = 13'h0000;
    localparam logic [PC_WIDTH-1:0]    PC_ONE       = 13'h0001;
    localparam logic [LOW_WIDTH-1:0]   PORT_ADDR    = 8'h00;
    localparam logic [DATA_WIDTH-1:0]  SELF_READ    = 8'h00;
    localparam logic [STACK_PTR_W-1:0] PTR_RESET    = 3'h0;
    localparam logic [STACK_PTR_W-1:0] PTR_ONE      = 3'h1;
    localparam logic [DATA_WIDTH-1:0]  LATCH_RESET  = 8'h00;
    localparam logic [DATA_WIDTH-1:0]  POINTER_RESET = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_STEP   = 3'b001,
        OP_JUMP   = 3'b010,
        OP_CALL   = 3'b011,
        OP_RETURN = 3'b100,
        OP_IRQ    = 3'b101,
        OP_PCLOW  = 3'b110
    } pc_op_t;
endpackage

// [hw/return_stack_mem.sv]
// Purpose: circular return address store
// Assumes: one push or pop per cycle
// Notes:   read data registered; pop value comes from the top entry
`timescale 1ns/1ps
module return_stack_mem
    import pc_stack_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int WIDTH = PC_WIDTH,
    parameter int PTR_W = STACK_PTR_W
) (
    input  wire logic             clk,
    input  wire logic             writeEn,
    input  wire logic [PTR_W-1:0] writeAddr,
    input  wire logic [WIDTH-1:0] writeData,
    input  wire logic [PTR_W-1:0] readAddr,
    output logic      [WIDTH-1:0] readData
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clk) begin
        if (writeEn) begin
            store[writeAddr] <= writeData;
        end
        readData <= store[readAddr];
    end
endmodule

// [hw/indirect_port.sv]
// Purpose: redirect virtual data port accesses through the pointer
// Assumes: data file answers reads combinationally
// Notes:   bank select is unused here, so the top address bit is held low
`timescale 1ns/1ps
module indirect_port
    import pc_stack_pkg::*;
(
    input  wire logic [LOW_WIDTH-1:0]   pointer,
    input  wire logic                   portRead,
    input  wire logic                   portWrite,
    input  wire logic [DATA_WIDTH-1:0]  fileReadData,
    output logic      [DADDR_WIDTH-1:0] address,
    output logic                        fileWrite,
    output logic      [DATA_WIDTH-1:0]  readData
);
    logic selfAddressed;

    always_comb begin
        selfAddressed = (pointer == PORT_ADDR);
        address       = {1'b0, pointer};
        fileWrite     = portWrite && !selfAddressed;
        readData      = selfAddressed ? SELF_READ : fileReadData;
        if (!portRead) begin
            readData = SELF_READ;
        end
    end
endmodule

// [hw/program_counter_stack_indirect.sv]
// Purpose: program counter, paging, return stack and indirect addressing of the core
// Assumes: decoder gives one op per cycle; data file reads are combinational
// Notes:   stack read data lag by one cycle, so the top entry is prefetched
`timescale 1ns/1ps
module program_counter_stack_indirect
    import pc_stack_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire pc_op_t                 op,
    input  wire logic [PAGE_WIDTH-1:0]  opTarget,
    input  wire logic [PC_WIDTH-1:0]    irqVector,
    input  wire logic [LOW_WIDTH-1:0]   pcLowWriteData,
    input  wire logic                   latchWrite,
    input  wire logic [DATA_WIDTH-1:0]  latchWriteData,
    input  wire logic                   pointerWrite,
    input  wire logic [DATA_WIDTH-1:0]  pointerWriteData,
    input  wire logic                   portRead,
    input  wire logic                   portWrite,
    input  wire logic [DATA_WIDTH-1:0]  portWriteData,
    input  wire logic [DATA_WIDTH-1:0]  fileReadData,
    output logic      [PC_WIDTH-1:0]    programCounter,
    output logic      [LOW_WIDTH-1:0]   pcLowByte,
    output logic      [DATA_WIDTH-1:0]  pcHighLatch,
    output logic      [DATA_WIDTH-1:0]  indirectPointer,
    output logic      [DADDR_WIDTH-1:0] fileAddress,
    output logic                        fileWrite,
    output logic      [DATA_WIDTH-1:0]  fileWriteData,
    output logic      [DATA_WIDTH-1:0]  portReadData
);
    logic [STACK_PTR_W-1:0] stackPtr;
    logic [STACK_PTR_W-1:0] next_stackPtr;
    logic [PC_WIDTH-1:0]    next_programCounter;
    logic [DATA_WIDTH-1:0]  next_pcHighLatch;
    logic [DATA_WIDTH-1:0]  next_indirectPointer;
    logic [PC_WIDTH-1:0]    stackTop;
    logic [PC_WIDTH-1:0]    returnAddr;
    logic                   push;
    logic                   pop;
    logic [STACK_PTR_W-1:0] readAddr;
    logic [PC_WIDTH-1:0]    pushData;
    logic [DADDR_WIDTH-1:0] portAddress;
    logic                   portFileWrite;
    logic [DATA_WIDTH-1:0]  portData;
    logic                   bypassValid;
    logic [PC_WIDTH-1:0]    bypassData;
    logic                   next_bypassValid;

    // pointer wraps freely; no overflow flag by design
    always_comb begin
        push          = (op == OP_CALL) || (op == OP_IRQ);
        pop           = (op == OP_RETURN);
        pushData      = programCounter + PC_ONE;
        next_stackPtr = stackPtr;
        if (push) begin
            next_stackPtr = stackPtr + PTR_ONE;
        end else if (pop) begin
            next_stackPtr = stackPtr - PTR_ONE;
        end
        // prefetch the entry that will be on top after this cycle
        readAddr = next_stackPtr - PTR_ONE;
        next_bypassValid = push;
    end

    return_stack_mem #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_WIDTH),
        .PTR_W (STACK_PTR_W)
    ) u_stack (
        .clk       (clk),
        .writeEn   (push),
        .writeAddr (stackPtr),
        .writeData (pushData),
        .readAddr  (readAddr),
        .readData  (stackTop)
    );

    // a push in the last cycle means the memory read raced the write
    always_comb begin
        returnAddr = bypassValid ? bypassData : stackTop;
    end

    always_comb begin
        next_programCounter = programCounter;
        unique case (op)
            OP_NONE:   next_programCounter = programCounter;
            OP_STEP:   next_programCounter = programCounter + PC_ONE;
            OP_JUMP, OP_CALL:
                next_programCounter = {pcHighLatch[PAGE_SEL_HI:PAGE_SEL_LO],
                                       opTarget};
            OP_RETURN: next_programCounter = returnAddr;
            OP_IRQ:    next_programCounter = irqVector;
            OP_PCLOW:
                next_programCounter = {pcHighLatch[UPPER_WIDTH-1:0],
                                       pcLowWriteData};
            default:   next_programCounter = programCounter;
        endcase
        // latch only changes on its own write
        next_pcHighLatch = latchWrite ? latchWriteData : pcHighLatch;
        next_indirectPointer = pointerWrite ? pointerWriteData : indirectPointer;
    end

    indirect_port u_port (
        .pointer      (indirectPointer),
        .portRead     (portRead),
        .portWrite    (portWrite),
        .fileReadData (fileReadData),
        .address      (portAddress),
        .fileWrite    (portFileWrite),
        .readData     (portData)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            programCounter  <= PC_RESET;
            pcLowByte       <= PC_RESET[LOW_WIDTH-1:0];
            stackPtr        <= PTR_RESET;
            pcHighLatch     <= LATCH_RESET;
            indirectPointer <= POINTER_RESET;
            bypassValid     <= 1'b0;
            bypassData      <= PC_RESET;
            fileAddress     <= {DADDR_WIDTH{1'b0}};
            fileWrite       <= 1'b0;
            fileWriteData   <= SELF_READ;
            portReadData    <= SELF_READ;
        end else begin
            programCounter  <= next_programCounter;
            pcLowByte       <= next_programCounter[LOW_WIDTH-1:0];
            stackPtr        <= next_stackPtr;
            pcHighLatch     <= next_pcHighLatch;
            indirectPointer <= next_indirectPointer;
            bypassValid     <= next_bypassValid;
            bypassData      <= pushData;
            fileAddress     <= portAddress;
            fileWrite       <= portFileWrite;
            fileWriteData   <= portWriteData;
            portReadData    <= portData;
        end
    end

    // helper: a push in the previous cycle, for the bypass cover
    logic lastWasPush;
    always_ff @(posedge clk) begin
        if (reset) begin
            lastWasPush <= 1'b0;
        end else begin
            lastWasPush <= push;
        end
    end

    property p_reset_clears;
        @(posedge clk) reset |=> (programCounter == PC_RESET);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("pc not cleared");

    property p_low_write;
        @(posedge clk) disable iff (reset)
        (op == OP_PCLOW)
            |=> (programCounter == {$past(pcHighLatch[UPPER_WIDTH-1:0]), $past(pcLowWriteData)});
    endproperty
    a_low_write: assert property (p_low_write) else $error("low write load wrong");

    property p_jump;
        @(posedge clk) disable iff (reset)
        (op == OP_JUMP || op == OP_CALL)
            |=> (programCounter == {$past(pcHighLatch[PAGE_SEL_HI:PAGE_SEL_LO]),
                                    $past(opTarget)});
    endproperty
    a_jump: assert property (p_jump) else $error("page load wrong");

    property p_step;
        @(posedge clk) disable iff (reset)
        (op == OP_STEP) |=> (programCounter == $past(programCounter) + PC_ONE);
    endproperty
    a_step: assert property (p_step) else $error("step wrong");

    property p_call_return;
        @(posedge clk) disable iff (reset)
        (op == OP_CALL) ##1 (op == OP_RETURN)
            |=> (programCounter == $past(programCounter, 2) + PC_ONE);
    endproperty
    a_call_return: assert property (p_call_return) else $error("return lost");

    property p_latch_hold;
        @(posedge clk) disable iff (reset)
        ((push || pop) && !latchWrite) |=> (pcHighLatch == $past(pcHighLatch));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

    property p_wrap;
        @(posedge clk) disable iff (reset)
        push && (&stackPtr) |=> (stackPtr == PTR_RESET);
    endproperty
    a_wrap: assert property (p_wrap) else $error("stack did not wrap");

    property p_self_read;
        @(posedge clk) disable iff (reset)
        (portRead && indirectPointer == PORT_ADDR) |=> (portReadData == SELF_READ);
    endproperty
    a_self_read: assert property (p_self_read) else $error("self read nonzero");

    property p_self_write;
        @(posedge clk) disable iff (reset)
        (portWrite && indirectPointer == PORT_ADDR) |=> !fileWrite;
    endproperty
    a_self_write: assert property (p_self_write) else $error("self write stored");

    property p_redirect;
        @(posedge clk) disable iff (reset)
        (portWrite && indirectPointer != PORT_ADDR)
            |=> (fileWrite && fileAddress == {1'b0, $past(indirectPointer)});
    endproperty
    a_redirect: assert property (p_redirect) else $error("redirect wrong");

    property p_low_mirror;
        @(posedge clk) disable iff (reset)
        pcLowByte == programCounter[LOW_WIDTH-1:0];
    endproperty
    a_low_mirror: assert property (p_low_mirror) else $error("low byte differs from pc");

    property p_hold;
        @(posedge clk) disable iff (reset)
        (op == OP_NONE) |=> (programCounter == $past(programCounter));
    endproperty
    a_hold: assert property (p_hold) else $error("pc moved while idle");

    property p_irq;
        @(posedge clk) disable iff (reset)
        (op == OP_IRQ) |=> (programCounter == $past(irqVector));
    endproperty
    a_irq: assert property (p_irq) else $error("irq vector not loaded");

    property p_irq_return;
        @(posedge clk) disable iff (reset)
        (op == OP_IRQ) ##1 (op == OP_RETURN)
            |=> (programCounter == $past(programCounter, 2) + PC_ONE);
    endproperty
    a_irq_return: assert property (p_irq_return) else $error("irq return lost");

    property p_push_ptr;
        @(posedge clk) disable iff (reset)
        push |=> (stackPtr == $past(stackPtr) + PTR_ONE);
    endproperty
    a_push_ptr: assert property (p_push_ptr) else $error("push did not advance");

    property p_pop_ptr;
        @(posedge clk) disable iff (reset)
        pop |=> (stackPtr == $past(stackPtr) - PTR_ONE);
    endproperty
    a_pop_ptr: assert property (p_pop_ptr) else $error("pop did not retreat");

    property p_idle_ptr;
        @(posedge clk) disable iff (reset)
        (!push && !pop) |=> $stable(stackPtr);
    endproperty
    a_idle_ptr: assert property (p_idle_ptr) else $error("stack pointer drifted");

    property p_read_redirect;
        @(posedge clk) disable iff (reset)
        (portRead && indirectPointer != PORT_ADDR)
            |=> (portReadData == $past(fileReadData));
    endproperty
    a_read_redirect: assert property (p_read_redirect) else $error("read not redirected");

    property p_access_addr;
        @(posedge clk) disable iff (reset)
        (portRead || portWrite) |=> (fileAddress == {1'b0, $past(indirectPointer)});
    endproperty
    a_access_addr: assert property (p_access_addr) else $error("data address wrong");

    property p_write_data;
        @(posedge clk) disable iff (reset)
        portWrite |=> (fileWriteData == $past(portWriteData));
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data wrong");

    property p_no_write;
        @(posedge clk) disable iff (reset)
        !portWrite |=> !fileWrite;
    endproperty
    a_no_write: assert property (p_no_write) else $error("spurious data write");

    property p_pointer_load;
        @(posedge clk) disable iff (reset)
        pointerWrite |=> (indirectPointer == $past(pointerWriteData));
    endproperty
    a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");

    c_call:   cover property (@(posedge clk) disable iff (reset) op == OP_CALL);
    c_ret:    cover property (@(posedge clk) disable iff (reset) lastWasPush && pop);
    c_wrap:   cover property (@(posedge clk) disable iff (reset) push && (&stackPtr));
    c_indir:  cover property (@(posedge clk) disable iff (reset)
                              portRead && indirectPointer != PORT_ADDR);
endmodule

// [tb/data_file_model.sv]
// Purpose: data register file seen through the indirect port
// Assumes: reads follow the pointer in the same cycle; writes land on the clock edge
// Notes:   preloaded with a pattern so that each address reads back differently
`timescale 1ns/1ps
module data_file_model
    import pc_stack_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic [LOW_WIDTH-1:0]   pointer,
    input  wire logic [DADDR_WIDTH-1:0] fileAddress,
    input  wire logic                   fileWrite,
    input  wire logic [DATA_WIDTH-1:0]  fileWriteData,
    output logic      [DATA_WIDTH-1:0]  fileReadData
);
    logic [DATA_WIDTH-1:0] mem [256];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end

    // combinational answer, as the core expects
    assign fileReadData = mem[pointer];

    always @(posedge clk) begin
        if (fileWrite) begin
            mem[fileAddress[7:0]] <= fileWriteData;
        end
    end
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench for counter, return stack and indirect port
// Assumes: ops spaced by an idle cycle, except in the back-to-back test
// Notes:   expected counter and stack are tracked in the bench
`timescale 1ns/1ps
module testbench;
    import pc_stack_pkg::*;
    logic clk, reset, latchWrite, pointerWrite, portRead, portWrite;
    pc_op_t op;
    logic [10:0] opTarget;
    logic [12:0] irqVector, programCounter, expPc;
    logic [7:0]  pcLowWriteData, latchWriteData, pointerWriteData, portWriteData;
    logic [7:0]  fileReadData, pcLowByte, pcHighLatch, indirectPointer;
    logic [7:0]  fileWriteData, portReadData;
    logic [8:0]  fileAddress;
    logic        fileWrite;
    logic [12:0] slots [8];
    logic [2:0]  sp;
    int errors = 0;
    int comparisons = 0;

    program_counter_stack_indirect i_program_counter_stack_indirect (
        .clk(clk), .reset(reset), .op(op), .opTarget(opTarget), .irqVector(irqVector),
        .pcLowWriteData(pcLowWriteData), .latchWrite(latchWrite),
        .latchWriteData(latchWriteData), .pointerWrite(pointerWrite),
        .pointerWriteData(pointerWriteData), .portRead(portRead), .portWrite(portWrite),
        .portWriteData(portWriteData), .fileReadData(fileReadData),
        .programCounter(programCounter), .pcLowByte(pcLowByte), .pcHighLatch(pcHighLatch),
        .indirectPointer(indirectPointer), .fileAddress(fileAddress), .fileWrite(fileWrite),
        .fileWriteData(fileWriteData), .portReadData(portReadData));
    data_file_model i_data_file_model (.clk(clk), .pointer(indirectPointer),
        .fileAddress(fileAddress), .fileWrite(fileWrite),
        .fileWriteData(fileWriteData), .fileReadData(fileReadData));

    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one op, then idle; outputs sampled once the edge has landed
    task automatic doOp(pc_op_t o, logic [12:0] v);
        @(posedge clk);
        op <= o;
        opTarget <= v[10:0];
        irqVector <= v;
        pcLowWriteData <= v[7:0];
        @(posedge clk);
        op <= OP_NONE;
        #1;
        check("pcLowByte", 16'(pcLowByte), 16'(programCounter[7:0]));
    endtask

    task automatic setReg(bit isLatch, logic [7:0] v);
        @(posedge clk);
        latchWrite <= isLatch;
        pointerWrite <= !isLatch;
        latchWriteData <= v;
        pointerWriteData <= v;
        @(posedge clk);
        latchWrite <= 0;
        pointerWrite <= 0;
        #1;
    endtask

    task automatic portAcc(bit rd, bit wr, logic [7:0] d);
        @(posedge clk);
        portRead <= rd;
        portWrite <= wr;
        portWriteData <= d;
        @(posedge clk);
        portRead <= 0;
        portWrite <= 0;
        #1;
    endtask

    task automatic t_pcl_and_step();
        setReg(1, 8'hff);
        doOp(OP_PCLOW, 13'h00ff);
        check("pc after low write", 16'(programCounter), 16'h1fff);
        doOp(OP_STEP, 13'h0);
        check("pc wrap", 16'(programCounter), 16'h0000);
        doOp(OP_NONE, 13'h0);
        check("pc hold", 16'(programCounter), 16'h0000);
        setReg(1, 8'h1c);
        doOp(OP_JUMP, 13'h07ab);
        check("pc after jump", 16'(programCounter), 16'h1fab);
        $display("test pcl_and_step done");
    endtask

    task automatic t_stack();
        logic [12:0] v;
        setReg(1, 8'h08);
        expPc = programCounter;
        sp = 3'h0;
        for (int i = 0; i < 9; i++) begin
            v = 13'h0100 + 13'(i);
            slots[sp] = expPc + 13'h1;
            sp = sp + 3'h1;
            doOp(i == 4 ? OP_IRQ : OP_CALL, v);
            expPc = (i == 4) ? v : {2'b01, v[10:0]};
            check("pc after push", 16'(programCounter), 16'(expPc));
        end
        for (int j = 0; j < 9; j++) begin
            sp = sp - 3'h1;
            doOp(OP_RETURN, 13'h0);
            check("pc after pop", 16'(programCounter), 16'(slots[sp]));
            check("latch kept", 16'(pcHighLatch), 16'h0008);
        end
        $display("test stack done");
    endtask

    // back-to-back push and pop take the bypass around the stack memory
    task automatic t_back_to_back();
        logic [12:0] start;
        start = programCounter;
        @(posedge clk);
        op <= OP_CALL;
        opTarget <= 11'h234;
        @(posedge clk);
        op <= OP_RETURN;
        #1;
        check("pc after call", 16'(programCounter), 16'h0a34);
        @(posedge clk);
        op <= OP_IRQ;
        irqVector <= 13'h0004;
        #1;
        check("pc after return", 16'(programCounter), 16'(start + 13'h1));
        @(posedge clk);
        op <= OP_RETURN;
        #1;
        check("pc after irq", 16'(programCounter), 16'h0004);
        @(posedge clk);
        op <= OP_NONE;
        #1;
        check("pc after irq return", 16'(programCounter), 16'(start + 13'h2));
        $display("test back_to_back done");
    endtask

    task automatic t_port();
        setReg(0, 8'h05);
        portAcc(1, 0, 8'h00);
        check("read data", 16'(portReadData), 16'h005f);
        check("file address", 16'(fileAddress), 16'h0005);
        setReg(0, 8'h06);
        check("pointer", 16'(indirectPointer), 16'h0006);
        portAcc(0, 1, 8'hc3);
        check("file write", 16'(fileWrite), 16'h0001);
        check("write data", 16'(fileWriteData), 16'h00c3);
        check("write address", 16'(fileAddress), 16'h0006);
        portAcc(1, 0, 8'h00);
        check("read back", 16'(portReadData), 16'h00c3);
        setReg(0, 8'h00);
        portAcc(1, 0, 8'h00);
        check("self read", 16'(portReadData), 16'h0000);
        portAcc(0, 1, 8'h77);
        check("self write", 16'(fileWrite), 16'h0000);
        $display("test port done");
    endtask

    task automatic t_reset();
        @(posedge clk);
        reset <= 1;
        @(posedge clk);
        reset <= 0;
        #1;
        check("pc after reset", 16'(programCounter), 16'h0000);
        $display("test reset done");
    endtask

    initial begin
        reset = 1;
        op = OP_NONE;
        {opTarget, irqVector, pcLowWriteData} = '0;
        {latchWrite, latchWriteData, pointerWrite, pointerWriteData} = '0;
        {portRead, portWrite, portWriteData} = '0;
        repeat (5) @(posedge clk);
        reset <= 0;
        @(posedge clk);
        #1;
        check("pc at start", 16'(programCounter), 16'h0000);
        t_pcl_and_step();
        t_stack();
        t_back_to_back();
        t_port();
        doOp(OP_STEP, 13'h0);
        t_reset();
        end_of_test();
    end

    // about 80 cycles of tests; a generous margin before giving up
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule
